// ---- include/meas_pkg.sv ----
// constants, field layouts and carrier types of the measurement sequencer
// Function
// - fast rate converts at maximum rate with 3.5 digits, else normal with 4.5
// - run mode starts conversions back to back with no trigger
// - triggered mode makes one measurement per trigger button press
// - external trigger needs jumper fitted; falling edge starts a trigger
// - line held low past the window keeps retriggering while low
// - external trigger acts only in triggered mode
// - chain order is averaging, offset-and-scale, one decibel calc, compare
// - null then low-frequency averaging run before the chain
// - absolute and relative decibel exclusive; latest selected one runs
// - one trigger runs one pass; run mode repeats until mode or function change
// - digits blank from pre-processing to completion when a calculation is on; result shown at completion
// - result beyond display capacity shows overflow indication
// - low-frequency averaging shows mean of four latest ac readings
// - constants load defaults at reset; count defaults 2, range 1 to 19999
// - invalid entry such as zero scale or reference keeps old constant
// - after enter the stored constant is displayed
// - constant holds until valid new entry or reset
// - enter without keyed digits loads the displayed measurement
// - compare gives high above both, low below both, else pass
// - diode readings above 1.999 V give overflow indication
// - overflow in resistance and diode; flashing in dc and ac voltage
package meas_pkg;
	localparam int VAL_W = 32;
	localparam int ADDR_W = 8;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TRIG   = 8'h08;
	localparam logic [7:0] OFS_KEY    = 8'h0c;
	localparam logic [7:0] OFS_ENTER  = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_CONST  = 8'h20;
	// ---------------------------------------------------------------
	// constants: index, default
	// ---------------------------------------------------------------
	localparam int NUM_CONST = 7;
	localparam logic [2:0] K_N = 3'h0;
	localparam logic [2:0] K_OFS = 3'h1;
	localparam logic [2:0] K_SCL = 3'h2;
	localparam logic [2:0] K_REF = 3'h3;
	localparam logic [2:0] K_LIM1 = 3'h4;
	localparam logic [2:0] K_LIM2 = 3'h5;
	localparam logic [2:0] K_NULL = 3'h6;
	localparam logic signed [31:0] N_DEF = 32'sh00000002;
	localparam logic signed [31:0] N_MIN = 32'sh00000001;
	localparam logic signed [31:0] N_MAX = 32'sh00004e1f;
	localparam logic signed [31:0] ONE_DEF = 32'sh00000001;
	localparam logic signed [31:0] ZERO_DEF = 32'sh00000000;
	// ---------------------------------------------------------------
	// display limits, functions, compare codes
	// ---------------------------------------------------------------
	localparam logic signed [31:0] CAP_45 = 32'sh00004e1f;
	localparam logic signed [31:0] CAP_35 = 32'sh000007cf;
	localparam logic signed [31:0] DIODE_MAX = 32'sh000007cf;
	localparam logic signed [31:0] DB_PER_OCT = 32'sh0000025a;
	localparam logic [2:0] FN_DCV = 3'h0;
	localparam logic [2:0] FN_ACV = 3'h1;
	localparam logic [2:0] FN_ACDC = 3'h2;
	localparam logic [2:0] FN_OHMS = 3'h3;
	localparam logic [2:0] FN_DIODE = 3'h4;
	localparam logic [1:0] CMP_NONE = 2'h0;
	localparam logic [1:0] CMP_LO = 2'h1;
	localparam logic [1:0] CMP_PASS = 2'h2;
	localparam logic [1:0] CMP_HI = 2'h3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int EXT_MIN_NS = 500;
	localparam int EXT_MAX_NS = 10000;
	localparam int EXT_MIN_CYC = (EXT_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int EXT_MAX_CYC = EXT_MAX_NS * CLK_MHZ / 1000;
	localparam int CNT_W = 12;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       cmpr;
		logic       relative_decibel_calc;
		logic       dbm;
		logic       ratio;
		logic       avg;
		logic       lfa;
		logic       nul;
		logic [2:0] func;
		logic       run;
		logic       fast;
	} ctrl_s;
	localparam int CTRL_W = 12;
	localparam logic [11:0] CTRL_RST = 12'h002;
	typedef struct packed {
		logic [31:0] value;
		logic        blank;
		logic        over;
		logic        flash;
		logic        digits45;
		logic        is_const;
		logic [1:0]  cmp;
	} disp_s;
endpackage : meas_pkg

// ---- rtl/div_unit.sv ----
// iterative signed divider shared by the calculation chain
`timescale 1ns/1ps
module div_unit #(
	parameter int W = 32
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                go,
	input  wire logic signed [W-1:0] num,
	input  wire logic signed [W-1:0] den,
	output logic                     done_q,
	output logic signed [W-1:0]      quot_q,
	output logic                     dz_q
);
	logic [W-1:0] n_q, d_q, n_nx;
	logic [W:0]   r_q, r_sh, r_nx;
	logic [6:0]   cnt_q;
	logic         busy_q, neg_q;

	always_comb begin
		r_sh = {r_q[W-1:0], n_q[W-1]};
		if (r_sh >= {1'b0, d_q}) begin
			r_nx = r_sh - {1'b0, d_q};
			n_nx = {n_q[W-2:0], 1'b1};
		end else begin
			r_nx = r_sh;
			n_nx = {n_q[W-2:0], 1'b0};
		end
	end

	// one quotient bit per clock; zero divisor answers at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_q <= '0;
			d_q <= '0;
			r_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			neg_q <= 1'b0;
			done_q <= 1'b0;
			quot_q <= '0;
			dz_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (go) begin
				n_q <= num[W-1] ? W'(-num) : num;
				d_q <= den[W-1] ? W'(-den) : den;
				r_q <= '0;
				cnt_q <= 7'(W);
				neg_q <= num[W-1] ^ den[W-1];
				dz_q <= (den == '0);
				busy_q <= (den != '0);
				if (den == '0) begin
					done_q <= 1'b1;
					quot_q <= '0;
				end
			end else if (busy_q) begin
				r_q <= r_nx;
				n_q <= n_nx;
				cnt_q <= cnt_q - 7'h01;
				if (cnt_q == 7'h01) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					quot_q <= neg_q ? W'(-n_nx) : n_nx;
				end
			end
		end
	end
endmodule : div_unit

// ---- rtl/meas_calc_seq.sv ----
// trigger and calculation sequencer with apb register access
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module meas_calc_seq
	import meas_pkg::*;
#(
	parameter int unsigned       EXT_LONG_CYC = EXT_MAX_CYC,
	parameter logic signed [31:0] DBM_REF     = 32'sh00001e42
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [31:0] conv_data,
	input  wire logic               conv_valid,
	input  wire logic               conv_over,
	output logic                    conv_start,
	output logic                    conv_fast,
	input  wire logic               ext_trig_n,
	input  wire logic               ext_jumper,
	output disp_s                   disp
);
	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_CONV  = 8'h02,
		S_PRE   = 8'h04,
		S_AVG   = 8'h08,
		S_RATIO = 8'h10,
		S_DB    = 8'h20,
		S_CMPR  = 8'h40,
		S_DONE  = 8'h80
	} state_e;

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic k_hit(input logic [7:0] a);
		return a[7:5] == 3'h1 && a[1:0] == 2'h0 && a[4:2] != 3'h7;
	endfunction : k_hit

	function automatic logic addr_ok(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_STATUS || a == OFS_TRIG ||
			a == OFS_KEY || a == OFS_ENTER || a == OFS_RESULT || k_hit(a);
	endfunction : addr_ok

	function automatic logic signed [31:0] k_def(input int i);
		if (i == int'(K_N))
			return N_DEF;
		if (i == int'(K_SCL) || i == int'(K_REF))
			return ONE_DEF;
		return ZERO_DEF;
	endfunction : k_def

	function automatic logic k_ok(input logic [2:0] i, input logic signed [31:0] v);
		if (i == K_N)
			return v >= N_MIN && v <= N_MAX;
		if (i == K_SCL || i == K_REF)
			return v != '0;
		return 1'b1;
	endfunction : k_ok

	// log2 with eight fraction bits, linear between octaves
	function automatic logic [12:0] log2q8(input logic [31:0] v);
		logic [4:0]  p;
		logic [31:0] s;
		p = '0;
		for (int i = 0; i < 32; i++)
			if (v[i])
				p = 5'(i);
		s = v << (5'd31 - p);
		return {p, s[30:23]};
	endfunction : log2q8

	state_e               st_q;
	ctrl_s                ctrl_q;
	logic signed [31:0]   konst_q [NUM_CONST];
	logic signed [31:0]   key_q, x_q, raw_q;
	logic signed [31:0]   hist_q [4];
	logic [1:0]           hidx_q;
	logic                 keyed_q, dbr_last_q, pend_q;
	logic                 jmp_q, jcap_q, ext_q;
	logic [CNT_W-1:0]     low_q;
	logic signed [31:0]   asum_q, dnum_q, dden_q;
	logic [15:0]          acnt_q;
	logic                 dgo_q, dwait_q, ovf_q, rov_q;
	logic [1:0]           cmp_q;
	logic                 ddone, dz;
	logic signed [31:0]   dquot;

	// ---------------------------------------------------------------
	// apb slave: decode in setup, answer in first access cycle
	// ---------------------------------------------------------------
	logic        setup, wr, ctrl_wr, enter_wr;
	ctrl_s       nc;
	logic [31:0] rmux;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & pready;
	assign ctrl_wr = wr && paddr == OFS_CTRL;
	assign enter_wr = wr && paddr == OFS_ENTER && pwdata[2:0] != 3'h7;
	assign nc = ctrl_s'(pwdata[CTRL_W-1:0]);

	logic calc_any, dbr_sel, dbm_sel, is_ac, mode_chg, calc_off;
	assign calc_any = ctrl_q.avg | ctrl_q.ratio | ctrl_q.dbm | ctrl_q.relative_decibel_calc | ctrl_q.cmpr;
	assign dbr_sel = ctrl_q.relative_decibel_calc & (~ctrl_q.dbm | dbr_last_q);
	assign dbm_sel = ctrl_q.dbm & ~dbr_sel;
	assign is_ac = ctrl_q.func == FN_ACV || ctrl_q.func == FN_ACDC;
	// mode or function change ends repetition
	assign mode_chg = ctrl_wr && (nc.run != ctrl_q.run || nc.func != ctrl_q.func);
	assign calc_off = ctrl_wr && !(nc.avg | nc.ratio | nc.dbm | nc.relative_decibel_calc | nc.cmpr);

	always_comb begin
		rmux = '0;
		if (k_hit(paddr))
			rmux = konst_q[paddr[4:2]];
		else if (paddr == OFS_CTRL)
			rmux = {20'h00000, ctrl_q};
		else if (paddr == OFS_STATUS)
			rmux = {24'h000000, dbm_sel, dbr_sel, jmp_q, pend_q,
				keyed_q, ovf_q, 1'b0, st_q != S_IDLE};
		else if (paddr == OFS_KEY)
			rmux = key_q;
		else if (paddr == OFS_RESULT)
			rmux = disp.value;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~addr_ok(paddr);
			prdata <= (setup & ~pwrite) ? rmux : '0;
		end
	end

	// ---------------------------------------------------------------
	// control register and decibel selection order
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ctrl_s'(CTRL_RST);
			dbr_last_q <= 1'b0;
			conv_fast <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= nc;
				if (nc.relative_decibel_calc & ~ctrl_q.relative_decibel_calc)
					dbr_last_q <= 1'b1;
				else if (nc.dbm & ~ctrl_q.dbm)
					dbr_last_q <= 1'b0;
			end
			conv_fast <= ctrl_q.fast;
		end
	end

	// ---------------------------------------------------------------
	// constants and keyed entry
	// ---------------------------------------------------------------
	logic signed [31:0] cand;
	logic               cand_ok;
	assign cand = keyed_q ? key_q : disp.value;
	assign cand_ok = k_ok(pwdata[2:0], cand);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CONST; i++)
				konst_q[i] <= k_def(i);
			key_q <= '0;
			keyed_q <= 1'b0;
		end else begin
			if (wr && paddr == OFS_KEY) begin
				key_q <= pwdata;
				keyed_q <= 1'b1;
			end
			// only a valid enter changes it
			if (enter_wr) begin
				keyed_q <= 1'b0;
				if (cand_ok)
					konst_q[pwdata[2:0]] <= cand;
			end
		end
	end

	// ---------------------------------------------------------------
	// triggers: button, external line, strap
	// ---------------------------------------------------------------
	logic ext_fall, ext_rep, trig_req;
	assign ext_fall = ext_q & ~ext_trig_n;
	assign ext_rep = ~ext_trig_n && low_q == CNT_W'(EXT_LONG_CYC) &&
		st_q == S_IDLE && !pend_q;
	assign trig_req = ~ctrl_q.run & ((wr && paddr == OFS_TRIG && pwdata[0]) |
		(jmp_q & (ext_fall | ext_rep)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jmp_q <= 1'b0;
			jcap_q <= 1'b0;
		end else if (!jcap_q) begin
			jmp_q <= ext_jumper;
			jcap_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b1;
			low_q <= '0;
		end else begin
			ext_q <= ext_trig_n;
			if (ext_trig_n)
				low_q <= '0;
			else if (low_q != CNT_W'(EXT_LONG_CYC))
				low_q <= low_q + 1'b1;
		end
	end

	// new request beats consumption in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_q <= 1'b0;
		else if (trig_req)
			pend_q <= 1'b1;
		else if (mode_chg || (st_q == S_IDLE && !ctrl_q.run))
			pend_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// pre-chain values and stage order
	// ---------------------------------------------------------------
	logic signed [31:0] pre_v, lf_v, rng_lo, rng_hi, dbref;
	logic signed [33:0] lf_sum;
	logic signed [13:0] ldiff;
	logic signed [31:0] dbv;

	function automatic state_e after(input int k, input ctrl_s c);
		if (k < 1 && c.avg)
			return S_AVG;
		if (k < 2 && c.ratio)
			return S_RATIO;
		if (k < 3 && (c.dbm | c.relative_decibel_calc))
			return S_DB;
		if (k < 4 && c.cmpr)
			return S_CMPR;
		return S_DONE;
	endfunction : after

	always_comb begin
		pre_v = ctrl_q.nul ? 32'(raw_q - konst_q[K_NULL]) : raw_q;
		lf_sum = 34'(pre_v);
		for (int i = 1; i < 4; i++)
			lf_sum = lf_sum + 34'(hist_q[2'(hidx_q - 2'(i))]);
		lf_v = 32'(lf_sum >>> 2);
		rng_lo = konst_q[K_LIM1] < konst_q[K_LIM2] ? konst_q[K_LIM1] : konst_q[K_LIM2];
		rng_hi = konst_q[K_LIM1] < konst_q[K_LIM2] ? konst_q[K_LIM2] : konst_q[K_LIM1];
		dbref = dbr_sel ? konst_q[K_REF] : DBM_REF;
		ldiff = $signed({1'b0, log2q8(x_q)}) - $signed({1'b0, log2q8(dbref)});
		dbv = (32'(ldiff) * DB_PER_OCT) >>> 8;
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_IDLE;
			conv_start <= 1'b0;
			raw_q <= '0;
			rov_q <= 1'b0;
			x_q <= '0;
			hidx_q <= '0;
			for (int i = 0; i < 4; i++)
				hist_q[i] <= '0;
			asum_q <= '0;
			acnt_q <= '0;
			dgo_q <= 1'b0;
			dwait_q <= 1'b0;
			dnum_q <= '0;
			dden_q <= '0;
			ovf_q <= 1'b0;
			cmp_q <= CMP_NONE;
		end else begin
			conv_start <= 1'b0;
			dgo_q <= 1'b0;
			if (mode_chg || calc_off) begin
				asum_q <= '0;
				acnt_q <= '0;
			end
			if (mode_chg) begin
				st_q <= S_IDLE;
				dwait_q <= 1'b0;
			end else begin
				unique case (st_q)
					S_IDLE: begin
						// run repeats, else one pass per trigger
						if (ctrl_q.run || pend_q) begin
							conv_start <= 1'b1;
							st_q <= S_CONV;
						end
					end
					S_CONV: begin
						if (conv_valid) begin
							raw_q <= conv_data;
							rov_q <= conv_over;
							st_q <= S_PRE;
						end
					end
					S_PRE: begin
						ovf_q <= 1'b0;
						cmp_q <= CMP_NONE;
						x_q <= pre_v;
						if (ctrl_q.lfa && is_ac) begin
							hist_q[hidx_q] <= pre_v;
							hidx_q <= hidx_q + 2'h1;
							x_q <= lf_v;
						end
						st_q <= after(0, ctrl_q);
					end
					S_AVG: begin
						if (!dwait_q) begin
							asum_q <= asum_q + x_q;
							acnt_q <= acnt_q + 16'h0001;
							dnum_q <= asum_q + x_q;
							dden_q <= 32'(acnt_q) + 32'sh00000001;
							dgo_q <= 1'b1;
							dwait_q <= 1'b1;
						end else if (ddone) begin
							x_q <= dquot;
							dwait_q <= 1'b0;
							// restart the mean after the count is reached
							if (32'(acnt_q) >= konst_q[K_N]) begin
								asum_q <= '0;
								acnt_q <= '0;
							end
							st_q <= after(1, ctrl_q);
						end
					end
					S_RATIO: begin
						if (!dwait_q) begin
							dnum_q <= x_q - konst_q[K_OFS];
							dden_q <= konst_q[K_SCL];
							dgo_q <= 1'b1;
							dwait_q <= 1'b1;
						end else if (ddone) begin
							x_q <= dquot;
							ovf_q <= ovf_q | dz;
							dwait_q <= 1'b0;
							st_q <= after(2, ctrl_q);
						end
					end
					S_DB: begin
						// log of a non-positive ratio cannot be shown
						if (x_q <= 0 || dbref <= 0)
							ovf_q <= 1'b1;
						x_q <= dbv;
						st_q <= after(3, ctrl_q);
					end
					S_CMPR: begin
						if (x_q > rng_hi)
							cmp_q <= CMP_HI;
						else if (x_q < rng_lo)
							cmp_q <= CMP_LO;
						else
							cmp_q <= CMP_PASS;
						st_q <= S_DONE;
					end
					S_DONE: st_q <= S_IDLE;
				endcase
			end
		end
	end

	div_unit #(.W(VAL_W)) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.go      (dgo_q),
		.num     (dnum_q),
		.den     (dden_q),
		.done_q  (ddone),
		.quot_q  (dquot),
		.dz_q    (dz)
	);

	// ---------------------------------------------------------------
	// display
	// ---------------------------------------------------------------
	logic signed [31:0] cap, mag;
	logic               res_ovf, fn_ohd, fn_v;
	assign cap = ctrl_q.fast ? CAP_35 : CAP_45;
	assign mag = x_q < 0 ? 32'(-x_q) : x_q;
	assign fn_ohd = ctrl_q.func == FN_OHMS || ctrl_q.func == FN_DIODE;
	assign fn_v = ctrl_q.func == FN_DCV || is_ac;
	assign res_ovf = ovf_q || mag > cap || (rov_q && fn_ohd) ||
		(ctrl_q.func == FN_DIODE && x_q > DIODE_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp <= '0;
			disp.digits45 <= 1'b1;
		end else begin
			disp.digits45 <= ~ctrl_q.fast;
			if (enter_wr) begin
				disp.value <= cand_ok ? cand : konst_q[pwdata[2:0]];
				disp.is_const <= 1'b1;
				disp.blank <= 1'b0;
				disp.over <= 1'b0;
				disp.flash <= 1'b0;
				disp.cmp <= CMP_NONE;
			end else if (st_q == S_PRE) begin
				disp.blank <= calc_any;
			end else if (st_q == S_DONE) begin
				disp.value <= x_q;
				disp.blank <= 1'b0;
				disp.is_const <= 1'b0;
				disp.over <= res_ovf;
				disp.flash <= rov_q && fn_v;
				disp.cmp <= cmp_q;
			end
		end
	end
endmodule : meas_calc_seq

// ---- verification/meas_calc_seq_chk.sv ----
// port assertions for the measurement sequencer
`timescale 1ns/1ps
module meas_calc_seq_chk
	import meas_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        conv_start,
	input wire logic        conv_fast
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rdy;
		psel && !penable |=> pready;
	endproperty
	a_rdy: assert property (p_rdy)
		else $error("no ready after setup");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one)
		else $error("ready longer than one cycle");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err)
		else $error("error without ready");
	property p_rdz;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdz: assert property (p_rdz)
		else $error("read data outside access");
	property p_bad;
		psel && !penable && paddr == 8'h18 |=> pslverr;
	endproperty
	a_bad: assert property (p_bad)
		else $error("unmapped access not refused");
	property p_map;
		psel && !penable && paddr == OFS_CTRL |=> !pslverr;
	endproperty
	a_map: assert property (p_map)
		else $error("mapped access refused");
	property p_fast;
		psel && penable && pready && pwrite && paddr == OFS_CTRL
			|-> ##2 conv_fast == $past(pwdata[0], 2);
	endproperty
	a_fast: assert property (p_fast)
		else $error("rate output not following control");
	property p_gap;
		conv_start |=> !conv_start;
	endproperty
	a_gap: assert property (p_gap)
		else $error("start longer than one cycle");
endmodule : meas_calc_seq_chk
bind meas_calc_seq meas_calc_seq_chk i_meas_calc_seq_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.conv_start(conv_start),
	.conv_fast(conv_fast)
);

// ---- verification/conv_model.sv ----
// converter stand-in answering each start after a set latency
`timescale 1ns/1ps
module conv_model (
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          conv_start,
	input wire logic [31:0]   val,
	input wire logic          ovr,
	input wire logic [7:0]    lat,
	output logic signed [31:0] conv_data,
	output logic              conv_valid,
	output logic              conv_over
);
	logic [7:0] cnt_q;
	logic       busy_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			conv_valid <= 1'b0;
			conv_data <= 32'h0;
			conv_over <= 1'b0;
		end else begin
			conv_valid <= 1'b0;
			// data not held outside the valid cycle
			conv_data <= ~conv_data;
			conv_over <= ~conv_over;
			if (conv_start) begin
				busy_q <= 1'b1;
				cnt_q <= lat;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b0;
				conv_valid <= 1'b1;
				conv_data <= val;
				conv_over <= ovr;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : conv_model

// ---- verification/tb_meas_calc_seq.sv ----
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module tb_meas_calc_seq
	import meas_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, ext_trig_n = 1'b1, ext_jumper = 1'b1, movr = 1'b0;
	logic [7:0]  paddr = 8'h00, mlat = 8'h03;
	logic [31:0] pwdata = 32'h0, mval = 32'h0, rd, prdata;
	logic        pready, pslverr, conv_start, conv_fast, conv_valid, conv_over;
	logic signed [31:0] conv_data;
	disp_s       disp;
	int          err_total = 0, total_checks = 0, nst = 0, s;
	logic [40:0] rows [13] = '{
		{1'b0, 8'h20, 32'h2}, {1'b0, 8'h28, 32'h1}, {1'b0, 8'h2c, 32'h1},
		{1'b0, 8'h30, 32'h0}, {1'b0, 8'h18, 32'h0}, {1'b0, 8'h00, 32'h2},
		{1'b1, 8'h0c, 32'h0}, {1'b1, 8'h10, 32'h2}, {1'b0, 8'h28, 32'h1},
		{1'b1, 8'h0c, 32'h4e20}, {1'b1, 8'h10, 32'h0}, {1'b0, 8'h20, 32'h2},
		{1'b0, 8'h2c, 32'h1}};
	always #20 pclk = ~pclk;
	always @(posedge pclk) if (conv_start === 1'b1) nst <= nst + 1;
	meas_calc_seq #(.EXT_LONG_CYC(20)) i_meas_calc_seq (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
		.conv_valid(conv_valid), .conv_over(conv_over), .conv_start(conv_start),
		.conv_fast(conv_fast), .ext_trig_n(ext_trig_n), .ext_jumper(ext_jumper), .disp(disp));
	conv_model i_conv_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
		.val(mval), .ovr(movr), .lat(mlat), .conv_data(conv_data),
		.conv_valid(conv_valid), .conv_over(conv_over));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk(32'(n), 32'h1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ent(input logic [31:0] i, input logic [31:0] v);
		apb(1'b1, OFS_KEY, v);
		apb(1'b1, OFS_ENTER, i);
	endtask : ent
	task automatic meas(input logic [31:0] d, input logic [31:0] ev, input logic [1:0] ec,
		input logic ov);
		int n;
		n = 0;
		mval <= d;
		apb(1'b1, OFS_TRIG, 32'h1);
		while (conv_valid !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		while (disp.blank !== 1'b0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		chk({31'h0, n < 400}, 32'h1);
		if (!ov) chk(disp.value, ev);
		chk({30'h0, disp.cmp}, {30'h0, ec});
		chk({31'h0, disp.over}, {31'h0, ov});
	endtask : meas
	task automatic pulse(input int len);
		// low time of len cycles, inside or past the retrigger window
		ext_trig_n <= 1'b0;
		repeat (len) @(posedge pclk);
		ext_trig_n <= 1'b1;
		repeat (40) @(posedge pclk);
	endtask : pulse
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s = nst;
		repeat (60) @(posedge pclk);
		chk({31'h0, nst - s > 3}, 32'h1);
		for (int i = 0; i < 13; i++) begin
			apb(rows[i][40], rows[i][39:32], rows[i][31:0]);
			if (!rows[i][40]) chk(rd, rows[i][31:0]);
		end
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		s = nst;
		meas(32'h7b, 32'h7b, CMP_NONE, 1'b0);
		chk(nst - s, 32'h1);
		chk({31'h0, disp.digits45}, 32'h1);
		apb(1'b1, OFS_ENTER, 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		chk(rd, 32'h7b);
		ent(32'h4, 32'h3c);
		repeat (2) @(posedge pclk);
		chk(disp.value, 32'h3c);
		chk({31'h0, disp.is_const}, 32'h1);
		ent(32'h5, 32'ha);
		ent(32'h1, 32'h64);
		ent(32'h2, 32'h2);
		mlat <= 8'h28;
		apb(1'b1, OFS_CTRL, 32'h900);
		meas(32'hc8, 32'h32, CMP_PASS, 1'b0);
		meas(32'h12c, 32'h64, CMP_HI, 1'b0);
		meas(32'h6e, 32'h5, CMP_LO, 1'b0);
		meas(32'hdc, 32'h3c, CMP_PASS, 1'b0);
		mlat <= 8'h01;
		apb(1'b1, OFS_CTRL, 32'h1);
		meas(32'h5dc, 32'h5dc, CMP_NONE, 1'b0);
		chk({31'h0, disp.digits45}, 32'h0);
		meas(32'h9c4, 32'h0, CMP_NONE, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h10);
		meas(32'h7cf, 32'h7cf, CMP_NONE, 1'b0);
		meas(32'h7d0, 32'h0, CMP_NONE, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h80);
		meas(32'h64, 32'h64, CMP_NONE, 1'b0);
		meas(32'hc8, 32'h96, CMP_NONE, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h44);
		meas(32'h190, 32'h64, CMP_NONE, 1'b0);
		ent(32'h6, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h20);
		meas(32'h64, 32'h54, CMP_NONE, 1'b0);
		movr <= 1'b1;
		meas(32'h64, 32'h54, CMP_NONE, 1'b0);
		chk({31'h0, disp.flash}, 32'h1);
		apb(1'b1, OFS_CTRL, 32'hc);
		meas(32'h64, 32'h0, CMP_NONE, 1'b1);
		movr <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h200);
		apb(1'b1, OFS_CTRL, 32'h600);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'hc0, 32'h40);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		s = nst;
		pulse(15);
		chk(nst - s, 32'h1);
		pulse(200);
		chk({31'h0, nst - s > 3}, 32'h1);
		ext_jumper <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h30, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		s = nst;
		pulse(15);
		chk(nst - s, 32'h0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		summarize();
	end
endmodule : tb_meas_calc_seq
